// ### mrp_pkg.sv
package mrp_pkg;
  localparam int unsigned MRP_ADDR_W = 32;
  localparam int unsigned MRP_DATA_W = 32;
  // axi4-lite response codes
  localparam logic [1:0] MRP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MRP_RESP_SLVERR = 2'h2;
  // native port qualifier levels
  localparam logic MRP_QUAL_WRITE = 1'b0;
  localparam logic MRP_QUAL_READ  = 1'b1;
  // device-side register window
  localparam int unsigned MRP_REG_COUNT = 16;
  localparam int unsigned MRP_IDX_W     = 4;
  localparam int unsigned MRP_IDX_LSB   = 2;
  localparam logic [MRP_DATA_W-1:0] MRP_REG_RESET = 32'h0000_0000;
  localparam logic [MRP_DATA_W-1:0] MRP_FAULT_DATA = 32'h0000_0000;
endpackage

// ### mrp_native_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mrp_native_if;
  import mrp_pkg::*;
  logic                  host_select_strobe;
  logic                  host_read_not_write;
  logic [MRP_ADDR_W-1:0] host_register_address;
  logic [MRP_DATA_W-1:0] host_write_word;
  logic [MRP_DATA_W-1:0] device_read_word;
  logic                  read_done_strobe;
  logic                  write_done_strobe;
  logic                  request_fault_flag;
  modport host (
    output host_select_strobe, host_read_not_write, host_register_address, host_write_word,
    input  device_read_word, read_done_strobe, write_done_strobe, request_fault_flag
  );
  modport device (
    input  host_select_strobe, host_read_not_write, host_register_address, host_write_word,
    output device_read_word, read_done_strobe, write_done_strobe, request_fault_flag
  );
endinterface
`default_nettype wire

// ### mrp_axil_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module mrp_axil_bridge (
  input  wire logic                           clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic [mrp_pkg::MRP_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                           s_axi_awvalid_i,
  output logic                                s_axi_awready_o,
  input  wire logic [mrp_pkg::MRP_DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]                     s_axi_wstrb_i,
  input  wire logic                           s_axi_wvalid_i,
  output logic                                s_axi_wready_o,
  output logic [1:0]                          s_axi_bresp_o,
  output logic                                s_axi_bvalid_o,
  input  wire logic                           s_axi_bready_i,
  input  wire logic [mrp_pkg::MRP_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                           s_axi_arvalid_i,
  output logic                                s_axi_arready_o,
  output logic [mrp_pkg::MRP_DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]                          s_axi_rresp_o,
  output logic                                s_axi_rvalid_o,
  input  wire logic                           s_axi_rready_i,
  mrp_native_if.host                          nat
);
  import mrp_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_WREQ  = 5'h02,
    ST_RREQ  = 5'h04,
    ST_BRESP = 5'h08,
    ST_RRESP = 5'h10
  } mrp_state_type;

  mrp_state_type         state_q;
  mrp_state_type         state_d;
  logic [MRP_ADDR_W-1:0] addr_q;
  logic [MRP_DATA_W-1:0] wdata_q;
  logic [MRP_DATA_W-1:0] rdata_q;
  logic [1:0]            resp_q;

  // reads win over writes when both arrive together; wstrb unused, native port is word wide
  wire idle     = (state_q == ST_IDLE);
  wire rd_take  = idle && s_axi_arvalid_i;
  wire wr_take  = idle && !s_axi_arvalid_i && s_axi_awvalid_i && s_axi_wvalid_i;
  wire wr_ack   = (state_q == ST_WREQ) && nat.write_done_strobe;
  wire rd_ack   = (state_q == ST_RREQ) && nat.read_done_strobe;
  wire [1:0] ack_resp = nat.request_fault_flag ? MRP_RESP_SLVERR : MRP_RESP_OKAY;

  assign s_axi_arready_o = rd_take;
  assign s_axi_awready_o = wr_take;
  assign s_axi_wready_o  = wr_take;
  assign s_axi_bvalid_o  = (state_q == ST_BRESP);
  assign s_axi_rvalid_o  = (state_q == ST_RRESP);
  assign s_axi_bresp_o   = resp_q;
  assign s_axi_rresp_o   = resp_q;
  assign s_axi_rdata_o   = rdata_q;

  assign nat.host_select_strobe    = (state_q == ST_WREQ) || (state_q == ST_RREQ);
  assign nat.host_read_not_write   = (state_q == ST_RREQ) ? MRP_QUAL_READ : MRP_QUAL_WRITE;
  assign nat.host_register_address = addr_q;
  assign nat.host_write_word       = wdata_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rd_take) begin
          state_d = ST_RREQ;
        end else if (wr_take) begin
          state_d = ST_WREQ;
        end
      end
      ST_WREQ:  if (wr_ack) state_d = ST_BRESP;
      ST_RREQ:  if (rd_ack) state_d = ST_RRESP;
      ST_BRESP: if (s_axi_bready_i) state_d = ST_IDLE;
      ST_RRESP: if (s_axi_rready_i) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (rd_take) begin
      addr_q  <= s_axi_araddr_i;
    end else if (wr_take) begin
      addr_q  <= s_axi_awaddr_i;
      wdata_q <= s_axi_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
      resp_q  <= MRP_RESP_OKAY;
    end else if (rd_ack) begin
      rdata_q <= nat.device_read_word;
      resp_q  <= ack_resp;
    end else if (wr_ack) begin
      resp_q  <= ack_resp;
    end
  end
endmodule // mrp_axil_bridge
`default_nettype wire

// ### mrp_reg_port.sv
`timescale 1ns/1ps
`default_nettype none
module mrp_reg_port (
  input  wire logic                           clk_i,
  input  wire logic                           rst_b_i,
  mrp_native_if.device                        nat,
  output logic [mrp_pkg::MRP_REG_COUNT*mrp_pkg::MRP_DATA_W-1:0] regs_o,
  output logic                                fault_pulse_o
);
  import mrp_pkg::*;

  logic [MRP_DATA_W-1:0] regs_q [MRP_REG_COUNT];
  logic [MRP_DATA_W-1:0] rdata_q;
  logic                  rack_q;
  logic                  wack_q;
  logic                  fault_q;

  wire busy    = rack_q || wack_q;
  // an ack cycle blocks a new take so a held request is not served twice
  wire take    = nat.host_select_strobe && !busy;
  wire rd_req  = take && (nat.host_read_not_write == MRP_QUAL_READ);
  wire wr_req  = take && (nat.host_read_not_write == MRP_QUAL_WRITE);
  wire [MRP_IDX_W-1:0] idx = nat.host_register_address[MRP_IDX_LSB +: MRP_IDX_W];
  // out-of-window or unaligned address is invalid
  wire bad     = (nat.host_register_address[MRP_ADDR_W-1:MRP_IDX_LSB+MRP_IDX_W] != '0)
              || (nat.host_register_address[MRP_IDX_LSB-1:0] != '0);

  assign nat.read_done_strobe   = rack_q;
  assign nat.write_done_strobe  = wack_q;
  assign nat.request_fault_flag = fault_q;
  assign nat.device_read_word   = rdata_q;
  assign fault_pulse_o          = fault_q;

  genvar g;
  for (g = 0; g < MRP_REG_COUNT; g++) begin : g_out
    assign regs_o[g*MRP_DATA_W +: MRP_DATA_W] = regs_q[g];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rack_q  <= 1'b0;
      wack_q  <= 1'b0;
      fault_q <= 1'b0;
      rdata_q <= MRP_REG_RESET;
    end else begin
      rack_q  <= rd_req;
      wack_q  <= wr_req;
      fault_q <= take && bad;
      if (rd_req) begin
        rdata_q <= bad ? MRP_FAULT_DATA : regs_q[idx];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < MRP_REG_COUNT; i++) begin
        regs_q[i] <= MRP_REG_RESET;
      end
    end else if (wr_req && !bad) begin
      regs_q[idx] <= nat.host_write_word;
    end
  end
endmodule // mrp_reg_port
`default_nettype wire

// ### mrp_props.sv
`timescale 1ns/1ps
`default_nettype none
module mrp_props (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        host_select_strobe,
  input wire logic        host_read_not_write,
  input wire logic [31:0] host_register_address,
  input wire logic [31:0] host_write_word,
  input wire logic [31:0] device_read_word,
  input wire logic        read_done_strobe,
  input wire logic        write_done_strobe,
  input wire logic        request_fault_flag
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // a held select during its ack cycle is not a new request
  wire logic ack  = read_done_strobe | write_done_strobe;
  wire logic take = host_select_strobe & ~ack;
  wire logic bad  = (|host_register_address[31:6]) | (|host_register_address[1:0]);
  wire logic rnw  = host_read_not_write;
  AST_WR: assert property (take && !rnw |=> write_done_strobe && !read_done_strobe)
    else $error("write not acked");
  AST_RD: assert property (take && rnw |=> read_done_strobe && !write_done_strobe)
    else $error("read not acked");
  AST_IDLE: assert property (!host_select_strobe |=> !ack)
    else $error("ack without select");
  AST_ONE: assert property (ack |=> !ack)
    else $error("ack longer than a cycle");
  AST_SEP: assert property (!(read_done_strobe && write_done_strobe))
    else $error("both acks high");
  AST_FLT: assert property (request_fault_flag |-> ack)
    else $error("fault without ack");
  AST_BAD: assert property (take |=> request_fault_flag == $past(bad))
    else $error("fault flag wrong");
  AST_ZERO: assert property (read_done_strobe && request_fault_flag |-> device_read_word == 0)
    else $error("bad read data not zero");
  AST_HOLD: assert property (take |=> host_select_strobe && $stable(host_register_address)
    && $stable(rnw) && $stable(host_write_word))
    else $error("request changed before ack");
endmodule // mrp_props
`default_nettype wire

// ### test_mgmt_register_port_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module test_mgmt_register_port_bridge;
  import mrp_pkg::*;
  logic clk_i = 0, rst_b_i = 0, awv = 0, wv = 0, arv = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0, rdata, mem[16];
  logic awr, wr_r, arr, bv, rv, fault;
  logic [1:0] bresp, rresp;
  logic [511:0] regs;
  logic [33:0] exp_q[$];
  int failures = 0, checks = 0, nflt = 0, fseen = 0, seed = 89;
  logic [31:0] badl[4] = '{32'h40, 32'h2, 32'h8000_0000, 32'h3D};
  mrp_native_if nat ();
  mrp_axil_bridge i_mrp_axil_bridge (.clk_i, .rst_b_i, .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
    .nat(nat));
  mrp_reg_port i_mrp_reg_port (.clk_i, .rst_b_i, .nat, .regs_o(regs), .fault_pulse_o(fault));
  mrp_props i_mrp_props (.clk_i, .rst_b_i, .host_select_strobe(nat.host_select_strobe),
    .host_read_not_write(nat.host_read_not_write), .host_write_word(nat.host_write_word),
    .host_register_address(nat.host_register_address), .device_read_word(nat.device_read_word),
    .read_done_strobe(nat.read_done_strobe), .write_done_strobe(nat.write_done_strobe),
    .request_fault_flag(nat.request_fault_flag));
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(string n, logic [33:0] s, logic [33:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  function automatic logic good(logic [31:0] a);
    return a[31:6] == 0 && a[1:0] == 0;
  endfunction
  // ready is sampled mid-cycle so the design's edge updates have landed
  task automatic wait_rdy(bit rd);
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (rd ? arr === 1'b1 : (awr & wr_r) === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      finish_test();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    if (good(a)) mem[a[5:2]] = d;
    nflt += !good(a);
    exp_q.push_back({good(a) ? MRP_RESP_OKAY : MRP_RESP_SLVERR, 32'h0});
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    wait_rdy(0);
    awv <= 0;
    wv <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic rd(logic [31:0] a);
    nflt += !good(a);
    exp_q.push_back(good(a) ? {MRP_RESP_OKAY, mem[a[5:2]]} : {MRP_RESP_SLVERR, MRP_FAULT_DATA});
    ara <= a;
    arv <= 1;
    wait_rdy(1);
    arv <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (fault === 1'b1) fseen++;
  always @(negedge clk_i) begin
    if (bv === 1'b1 || rv === 1'b1) begin
      if (exp_q.size() == 0) check("queue", 0, 1);
      else check("resp", bv ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1;
    @(posedge clk_i);
    for (int i = 0; i < 16; i++) wr(i * 4, $random(seed));
    for (int i = 15; i >= 0; i--) rd(i * 4);
    // faulty places must leave the registers untouched
    foreach (badl[k]) begin
      wr(badl[k], $random(seed));
      rd(badl[k]);
    end
    repeat (24) begin
      if ($random(seed) & 1) wr($random(seed) & 32'h4F, $random(seed));
      else rd($random(seed) & 32'h4F);
    end
    for (int i = 0; i < 16; i++) check("reg", regs[i*32+:32], mem[i]);
    check("faults", fseen, nflt);
    check("pending", exp_q.size(), 0);
    finish_test();
  end
endmodule // test_mgmt_register_port_bridge
`default_nettype wire
